// ==== acpc_pkg.sv ====
// Package with the register map, field layout and pad numbering of the pad control block.
package acpc_pkg;

    localparam int NUM_PADS = 11;
    localparam int ADDR_WIDTH = 12;
    localparam int IDX_WIDTH = 4;

    // Byte addresses of the pad control registers, one aligned word per pad.
    localparam logic [11:0] PIN44_CONTROL_ADDR = 12'h0b4;
    localparam logic [11:0] PIN45_CONTROL_ADDR = 12'h0b8;
    localparam logic [11:0] PIN46_CONTROL_ADDR = 12'h0bc;
    localparam logic [11:0] PIN47_CONTROL_ADDR = 12'h0c0;
    localparam logic [11:0] PIN48_CONTROL_ADDR = 12'h0c4;
    localparam logic [11:0] PIN49_CONTROL_ADDR = 12'h0c8;
    localparam logic [11:0] PIN50_CONTROL_ADDR = 12'h0cc;
    localparam logic [11:0] PIN51_CONTROL_ADDR = 12'h0d0;
    localparam logic [11:0] PIN52_CONTROL_ADDR = 12'h0d4;
    localparam logic [11:0] PIN53_CONTROL_ADDR = 12'h0d8;
    localparam logic [11:0] PIN54_CONTROL_ADDR = 12'h0dc;
    localparam logic [11:0] FIRST_ADDR = PIN44_CONTROL_ADDR;
    localparam logic [11:0] LAST_ADDR = PIN54_CONTROL_ADDR;

    // Pad positions inside the register array.
    localparam int PAD44 = 0;
    localparam int PAD45 = 1;
    localparam int PAD46 = 2;
    localparam int PAD47 = 3;
    localparam int PAD48 = 4;
    localparam int PAD49 = 5;
    localparam int PAD50 = 6;
    localparam int PAD51 = 7;
    localparam int PAD52 = 8;
    localparam int PAD53 = 9;
    localparam int PAD54 = 10;

    // Field layout.
    localparam int DRIVE_LSB = 12;
    localparam int DRIVE_MSB = 14;
    localparam int PULLDOWN_BIT = 9;
    localparam int PULLUP_BIT = 8;
    localparam int RECEIVER_BIT = 7;
    localparam int DRIVER_BIT = 6;
    localparam int ANALOG_BIT = 4;
    localparam int FUNC_LSB = 0;
    localparam int FUNC_MSB = 3;

    localparam logic [31:0] PAD_RESET = 32'h0000_1010;
    localparam logic [31:0] PAD_WRITE_MASK = 32'h0000_7fdf;

    typedef enum logic [3:0] {
        ACPC_FUNC_SOFT = 4'h0,
        ACPC_FUNC_ALT1 = 4'h1,
        ACPC_FUNC_ALT2 = 4'h2,
        ACPC_FUNC_ALT3 = 4'h3,
        ACPC_FUNC_ALT4 = 4'h4
    } acpc_func_t;

endpackage

// ==== acpc_pad_register.sv ====
// One pad control register with its write mask and reset value.
module acpc_pad_register
    import acpc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic writeEn,
    input wire logic [31:0] writeData,
    output logic [31:0] value
);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value <= PAD_RESET;
        end else if (writeEn) begin
            value <= writeData & PAD_WRITE_MASK;
        end
    end

endmodule // acpc_pad_register

// ==== acpc_pad_control.sv ====
// Top of the analog capable pad control block: APB registers and pad routing.
//
// The APB slave port is this design's own decision.
module acpc_pad_control
    import acpc_pkg::*;
#(
    parameter int PADS = NUM_PADS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PADS-1:0] padIn,
    output logic [PADS-1:0] padOut,
    output logic [PADS-1:0] padOe,
    output logic [3*PADS-1:0] driveStrengthSel,
    output logic [PADS-1:0] weakPulldownEn,
    output logic [PADS-1:0] weakPullupEn,
    output logic [PADS-1:0] inputReceiverEn,
    output logic [PADS-1:0] analogSwitchEn,
    input wire logic [PADS-1:0] softOut,
    output logic [PADS-1:0] softIn,
    input wire logic digitalMicClock,
    output logic digitalMicData,
    input wire logic audioTxWordClock,
    input wire logic audioRxAWordClock,
    input wire logic audioRxBWordClock,
    input wire logic audioTxDataOut,
    output logic audioRxADataIn,
    output logic audioRxBDataIn,
    input wire logic pulseModChThree,
    input wire logic pulseModChFive
);

    function automatic logic addrHit(input logic [ADDR_WIDTH-1:0] addr);
        return (addr >= FIRST_ADDR) && (addr <= LAST_ADDR) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [IDX_WIDTH-1:0] addrIndex(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] offset;
        offset = addr - FIRST_ADDR;
        return offset[IDX_WIDTH+1:2];
    endfunction

    logic [31:0] regValue [PADS];
    logic [PADS-1:0] syncA;
    logic [PADS-1:0] syncB;
    logic [3:0] funcSel [PADS];
    logic [PADS-1:0] driverEn;
    logic [PADS-1:0] digitalMode;
    logic [PADS-1:0] heardIn;
    logic [PADS-1:0] next_padOut;

    wire addrOk = addrHit(paddr);
    wire [IDX_WIDTH-1:0] regIndex = addrIndex(paddr);
    wire setupPhase = psel && !penable;
    wire writeAccess = psel && penable && pwrite && addrOk;

    // Zero wait states: read data is captured in the setup cycle, so pready is always high.
    assign pready = 1'b1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= (addrOk && !pwrite) ? regValue[regIndex] : 32'h0000_0000;
            pslverr <= !addrOk;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PADS; g++) begin : gen_pad
            acpc_pad_register u_reg (
                .clock(clock),
                .rst_n(rst_n),
                .writeEn(writeAccess && (regIndex == IDX_WIDTH'(g))),
                .writeData(pwdata),
                .value(regValue[g])
            );
            assign driveStrengthSel[3*g +: 3] = regValue[g][DRIVE_MSB:DRIVE_LSB];
            assign weakPulldownEn[g] = regValue[g][PULLDOWN_BIT];
            assign weakPullupEn[g] = regValue[g][PULLUP_BIT];
            assign analogSwitchEn[g] = regValue[g][ANALOG_BIT];
            assign digitalMode[g] = !regValue[g][ANALOG_BIT];
            assign funcSel[g] = regValue[g][FUNC_MSB:FUNC_LSB];
            assign driverEn[g] = regValue[g][DRIVER_BIT];
            // In analog mode the digital receiver is parked so the analog level is not loaded.
            assign inputReceiverEn[g] = regValue[g][RECEIVER_BIT] && digitalMode[g];
            assign heardIn[g] = syncB[g] && inputReceiverEn[g];
            assign padOe[g] = driverEn[g] && digitalMode[g];
        end
    endgenerate

    // Reserved codes on any pad fall back to the software pin value; software must avoid them.
    always_comb begin
        next_padOut = softOut;
        if (funcSel[PAD44] == ACPC_FUNC_ALT1) begin
            next_padOut[PAD44] = digitalMicClock;
        end
        unique case (funcSel[PAD51])
            ACPC_FUNC_ALT1: next_padOut[PAD51] = audioTxWordClock;
            ACPC_FUNC_ALT2: next_padOut[PAD51] = audioRxAWordClock;
            ACPC_FUNC_ALT3: next_padOut[PAD51] = audioRxBWordClock;
            ACPC_FUNC_ALT4: next_padOut[PAD51] = pulseModChThree;
            default: next_padOut[PAD51] = softOut[PAD51];
        endcase
        unique case (funcSel[PAD53])
            ACPC_FUNC_ALT1: next_padOut[PAD53] = audioTxDataOut;
            ACPC_FUNC_ALT4: next_padOut[PAD53] = pulseModChFive;
            default: next_padOut[PAD53] = softOut[PAD53];
        endcase
    end

    wire micDataSel = funcSel[PAD45] == ACPC_FUNC_ALT1;
    wire rxASel = funcSel[PAD53] == ACPC_FUNC_ALT2;
    wire rxBSel = funcSel[PAD53] == ACPC_FUNC_ALT3;

    // Pads are asynchronous; only the second stage is read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= padIn;
            syncB <= syncA;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            padOut <= '0;
            softIn <= '0;
            digitalMicData <= 1'b0;
            audioRxADataIn <= 1'b0;
            audioRxBDataIn <= 1'b0;
        end else begin
            padOut <= next_padOut;
            softIn <= heardIn;
            digitalMicData <= micDataSel && heardIn[PAD45];
            audioRxADataIn <= rxASel && heardIn[PAD53];
            audioRxBDataIn <= rxBSel && heardIn[PAD53];
        end
    end

endmodule // acpc_pad_control

// ==== acpc_pad_control_assertions.sv ====
// Port level properties of the pad control block.
module acpc_pad_control_checker
    import acpc_pkg::*;
#(
    parameter int PADS = NUM_PADS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [PADS-1:0] padOe,
    input wire logic [3*PADS-1:0] driveStrengthSel,
    input wire logic [PADS-1:0] weakPulldownEn,
    input wire logic [PADS-1:0] weakPullupEn,
    input wire logic [PADS-1:0] inputReceiverEn,
    input wire logic [PADS-1:0] analogSwitchEn
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic acc = psel && penable;
    wire logic hit = paddr >= FIRST_ADDR && paddr <= LAST_ADDR && paddr[1:0] == 2'h0;
    chk_bad_addr: assert property (acc && !hit |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_good_addr: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    chk_reserved_zero: assert property (acc && !pwrite |-> prdata[31:15] == 17'h0_0000 && !prdata[5])
        else $error("reserved bits read nonzero");
    chk_analog_no_drive: assert property ((padOe & analogSwitchEn) == '0)
        else $error("driver on in analog mode");
    chk_analog_no_rx: assert property ((inputReceiverEn & analogSwitchEn) == '0)
        else $error("receiver on in analog mode");
    chk_reset_analog: assert property (!$past(rst_n) |-> &analogSwitchEn && driveStrengthSel == {PADS{3'h1}})
        else $error("wrong mode or strength after reset");
    chk_reset_pulls: assert property (!$past(rst_n) |-> weakPulldownEn == '0 && weakPullupEn == '0)
        else $error("pull enabled after reset");
    chk_reset_buffers: assert property (!$past(rst_n) |-> padOe == '0 && inputReceiverEn == '0)
        else $error("buffer enabled after reset");
    cover property (acc && pwrite && hit);
    cover property (acc && !hit);
    cover property ($fell(analogSwitchEn[7]));
endmodule // acpc_pad_control_checker

bind acpc_pad_control acpc_pad_control_checker #(.PADS(PADS)) chk (.clock, .rst_n, .paddr, .psel,
    .penable, .pwrite, .prdata, .pslverr, .padOe, .driveStrengthSel, .weakPulldownEn,
    .weakPullupEn, .inputReceiverEn, .analogSwitchEn);

// ==== acpc_pad_control_tb.sv ====
// Self-checking testbench of the pad control block.
module acpc_pad_control_tb import acpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RA [7] = '{12'h0b4, 12'h0d0, 12'h0d0, 12'h0d0, 12'h0d0, 12'h0d8, 12'h0d8};
    localparam logic [3:0] RC [7] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h1};
    localparam int RP [7] = '{0, 7, 7, 7, 7, 9, 9};
    localparam int RS [7] = '{5, 0, 1, 2, 3, 4, 6};
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, seed = 32'h0000_b384;
    logic [10:0] padIn = '0, softOut = '0, padOut, padOe;
    logic [6:0] src = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [10:0] softIn;
    logic digitalMicData, audioRxADataIn, audioRxBDataIn;
    logic [6:0] note;
    logic [6:0] pinq [$];
    // The pad outputs, output enables and received inputs in one vector, so a note only has to name a bit of it.
    wire [35:0] watch = {audioRxBDataIn, audioRxADataIn, digitalMicData, softIn, padOe, padOut};
    int miscompares = 0, n_compared = 0, cycles = 0;
    logic [32:0] expq [$];
    acpc_pad_control uut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .padIn, .padOut, .padOe, .driveStrengthSel(), .weakPulldownEn(),
        .weakPullupEn(), .inputReceiverEn(), .analogSwitchEn(), .softOut, .softIn,
        .digitalMicClock(src[5]), .digitalMicData, .audioTxWordClock(src[0]),
        .audioRxAWordClock(src[1]), .audioRxBWordClock(src[2]), .audioTxDataOut(src[6]),
        .audioRxADataIn, .audioRxBDataIn, .pulseModChThree(src[3]), .pulseModChFive(src[4]));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
        if (!w) expq.push_back(e);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clock) penable <= 1'b1;
        @(posedge clock iff pready === 1'b1);
    endtask
    always #4 clock = ~clock;
    always @(posedge clock) begin
        seed <= xs(seed);
        {padIn, softOut, src} <= seed[28:0];
        cycles <= cycles + 1;
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expq.pop_front());
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    // Pad results settle after the rising edge, so they are compared at the falling edge.
    always @(negedge clock) begin
        while (pinq.size() > 0) begin
            note = pinq.pop_front();
            check(33'(watch[note[6:1]]), 33'(note[0]));
        end
    end
    initial begin
        logic [31:0] d;
        logic e;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 11; i++) apb(FIRST_ADDR + 12'(4 * i), 0, '0, {1'b0, PAD_RESET});
        apb(12'h0e0, 1, 32'hffff_ffff, '0);
        apb(12'h0e0, 0, '0, {1'b1, 32'h0000_0000});
        apb(12'h0b6, 0, '0, {1'b1, 32'h0000_0000});
        for (int i = 0; i < 11; i++) begin
            d = seed & 32'hffff_fff0;
            apb(FIRST_ADDR + 12'(4 * i), 1, d, '0);
            apb(FIRST_ADDR + 12'(4 * i), 0, '0, {1'b0, d & PAD_WRITE_MASK});
        end
        for (int k = 0; k < 7; k++) begin
            apb(RA[k], 1, 32'h0000_1040 | 32'(RC[k]), '0);
            psel <= 1'b0; penable <= 1'b0;
            pinq.push_back({6'(11 + RP[k]), 1'b1});
            repeat (4) begin
                #1 e = src[RS[k]];
                @(posedge clock);
                pinq.push_back({6'(RP[k]), e});
            end
            @(posedge clock);
        end
        // A pad level takes two synchroniser stages and the output flop to show up.
        for (int k = 0; k < 3; k++) begin
            apb(k == 0 ? 12'h0b8 : 12'h0d8, 1, 32'h0000_1080 | 32'(k + 1), '0);
            psel <= 1'b0; penable <= 1'b0;
            repeat (3) begin
                #1 e = padIn[k == 0 ? 1 : 9];
                repeat (3) @(posedge clock);
                pinq.push_back({6'(33 + k), e});
                pinq.push_back({6'(k == 0 ? 23 : 31), e});
            end
        end
        apb(12'h0d0, 1, 32'h0000_1050, '0);
        psel <= 1'b0; penable <= 1'b0;
        pinq.push_back({6'h12, 1'b0});
        @(posedge clock) rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        apb(12'h0d0, 0, '0, {1'b0, PAD_RESET});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        summarize();
    end
endmodule // acpc_pad_control_tb
